// file: hdl/ecpp_pkg.sv
// package of the extended parallel port register block: offsets, fields, reset values, types
// assumes a host register port with byte-wide data and one clock domain
`default_nettype none
package ecpp_pkg;

   // ********************************************
   // register offsets (port address, 11 bits)
   // ********************************************
   localparam logic [10:0] OFS_DATA   = 11'h000;
   localparam logic [10:0] OFS_STATUS = 11'h001;
   localparam logic [10:0] OFS_CTRL   = 11'h002;
   localparam logic [10:0] OFS_FIFO   = 11'h400;
   localparam logic [10:0] OFS_CFGB   = 11'h401;
   localparam logic [10:0] OFS_EXTCTL = 11'h402;
   localparam logic [10:0] OFS_THRESH = 11'h403;

   // ********************************************
   // fixed values and reset values
   // ********************************************
   localparam logic [7:0] CFGA_VALUE      = 8'h10;
   localparam logic [7:0] CTRL_RESET      = 8'h00;
   localparam logic [2:0] CFGB_IRQ_RESET  = 3'h0;
   localparam logic [2:0] CFGB_LOW_ONES   = 3'h7;
   localparam logic [1:0] CTRL_HIGH_ONES  = 2'h3;
   localparam logic [2:0] STATUS_LOW_ONES = 3'h7;
   localparam logic [3:0] FREE_THR_RESET  = 4'h8;
   localparam logic [3:0] FILL_THR_RESET  = 4'h8;

   // ********************************************
   // field positions
   // ********************************************
   localparam int CTRL_DIR_BIT   = 5;
   localparam int CTRL_ACKIE_BIT = 4;
   localparam int CTRL_SELIN_BIT = 3;
   localparam int CTRL_INIT_BIT  = 2;
   localparam int CTRL_AFD_BIT   = 1;
   localparam int CTRL_STB_BIT   = 0;
   localparam int EXT_FAULTB_BIT = 4;
   localparam int EXT_TRANSFER_REQUEST_ENABLE_BIT  = 3;
   localparam int EXT_SVC_BIT    = 2;

   // ********************************************
   // fifo shape
   // ********************************************
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW    = 4;

   typedef enum logic [2:0] {
      MODE_SPP  = 3'h0,
      MODE_PS2  = 3'h1,
      MODE_PFIFO = 3'h2,
      MODE_ECP  = 3'h3,
      MODE_EPP  = 3'h4,
      MODE_RSVD = 3'h5,
      MODE_TEST = 3'h6,
      MODE_CFG  = 3'h7
   } ecpp_mode_t;

   // host register port request
   typedef struct packed {
      logic [10:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } ecpp_req_t;

   // peripheral inputs
   typedef struct packed {
      logic busy;
      logic ackN;
      logic paperError;
      logic select;
      logic faultN;
   } ecpp_pins_in_t;

   // peripheral control outputs
   typedef struct packed {
      logic strobeN;
      logic autoFeedN;
      logic initN;
      logic selectInN;
   } ecpp_pins_out_t;

   // fifo entry: tag high marks an address/run-length byte
   typedef struct packed {
      logic       tag;
      logic [7:0] data;
   } ecpp_entry_t;

   // link handshake states, gray along the forward path
   typedef enum logic [1:0] {
      LK_IDLE   = 2'b00,
      LK_SETUP  = 2'b01,
      LK_STROBE = 2'b11,
      LK_WAIT   = 2'b10
   } ecpp_link_t;

endpackage
`default_nettype wire

// file: hdl/ecpp_fifo.sv
// common sixteen-entry fifo of the port, tagged entries
// assumes one clock; caller never pushes when full nor pops when empty
`default_nettype none
module ecpp_fifo (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic                 flush,
   input  wire logic                 push,
   input  wire ecpp_pkg::ecpp_entry_t pushData,
   input  wire logic                 pop,
   output ecpp_pkg::ecpp_entry_t      headData,
   output logic [4:0]                count,
   output logic                      full,
   output logic                      empty
);
   import ecpp_pkg::*;

   typedef struct packed {
      logic [FIFO_AW-1:0] wp;
      logic [FIFO_AW-1:0] rp;
      logic [4:0]         cnt;
   } ecpp_fifo_st_t;

   ecpp_fifo_st_t st_r;
   ecpp_fifo_st_t st_nxt;
   ecpp_entry_t   mem [FIFO_DEPTH];

   always_comb begin
      st_nxt = st_r;
      if (flush) begin
         st_nxt = '0;
      end else begin
         if (push) st_nxt.wp = st_r.wp + 4'h1;
         if (pop) st_nxt.rp = st_r.rp + 4'h1;
         if (push && !pop) st_nxt.cnt = st_r.cnt + 5'h01;
         else if (pop && !push) st_nxt.cnt = st_r.cnt - 5'h01;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) st_r <= '0;
      else st_r <= st_nxt;
   end

   always_ff @(posedge clk) begin
      if (push && !flush) mem[st_r.wp] <= pushData;
   end

   assign headData = mem[st_r.rp];
   assign count    = st_r.cnt;
   assign full     = (st_r.cnt == 5'h10);
   assign empty    = (st_r.cnt == 5'h00);
endmodule
`default_nettype wire

// file: hdl/ecpp_port.sv
// register set, mode control and link handshakes of the extended parallel port
// assumes host register port synchronous to clk; peripheral pins synchronised upstream
`default_nettype none

// Functional notes
// - address-count port queues tagged bytes, forward only
// - status reads inverted busy, four inputs, ones
// - direction ignored in modes 000, 010
// - acknowledge rising edge interrupts when enabled
// - control bits drive select, init, feed, strobe
// - parallel-fifo mode sends bytes by printer handshake
// - forward ecp mode sends fifo bytes automatically
// - reverse ecp mode receives peripheral bytes into fifo
// - test mode fifo never transmitted to peripheral; pdOut here carries the last popped byte
// - config A reads constant 10h
// - config B bit7 zero, low bits one
// - config B bit6 shows irq line level
// - config B irq select field, default 000
// - mode field read-write; mode 000 clears fifo
// - mode 001 tristates data when direction bit set, reads live lines
// - address and data bytes share fifo in order
// - mode 111 exposes config registers at 400,401
// - fault falling edge interrupt in mode 011 unless blocked
// - transfer request enable gates dma requests
// - service flag set by events, software clears
// - service events: terminal count, thresholds
// - shared sixteen-byte fifo with full, empty bits
module ecpp_port (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire ecpp_pkg::ecpp_req_t    hostReq,
   output logic [7:0]                  hostRdata,
   input  wire ecpp_pkg::ecpp_pins_in_t pinsIn,
   output ecpp_pkg::ecpp_pins_out_t    pinsOut,
   input  wire logic [7:0]             pdIn,
   output logic [7:0]                  pdOut,
   output logic                        pdOe,
   input  wire logic                   dmaAck,
   input  wire logic                   dmaTc,
   output logic                        dmaReq,
   output logic                        irqOut,
   input  wire logic                   irqLineLevel
);
   import ecpp_pkg::*;

   // ********************************************
   // state
   // ********************************************
   typedef struct packed {
      logic [7:0]  dataLatch;
      logic [7:0]  ctrl;
      ecpp_mode_t  mode;
      logic        faultBlock;
      logic        xferReqEnable;
      logic        serviceFlag;
      logic [2:0]  irqSelect;
      logic [3:0]  freeThr;
      logic [3:0]  fillThr;
      logic [7:0]  rdata;
      logic [7:0]  lastPop;
      ecpp_link_t  link;
      logic        linkTag;
      logic        ackPrev;
      logic        faultPrev;
      logic        irq;
   } ecpp_state_t;

   ecpp_state_t st_r;
   ecpp_state_t st_nxt;

   ecpp_entry_t fifoHead;
   ecpp_entry_t fifoIn;
   logic [4:0]  fifoCount;
   logic        fifoFull;
   logic        fifoEmpty;
   logic        fifoPush;
   logic        fifoPop;
   logic        fifoFlush;
   logic        dirIn;
   logic        fifoMode;
   logic        fwdXfer;
   logic        revXfer;
   logic        hostFifoWr;
   logic        hostFifoRd;
   logic        linkPop;
   logic        linkPush;
   logic        svcEvent;
   logic [4:0]  freeSpace;
   logic [7:0]  statusVal;
   logic [7:0]  ctrlRead;
   logic [7:0]  cfgbRead;
   logic [7:0]  extRead;

   ecpp_fifo u_fifo (
      .clk      (clk),
      .reset_n  (reset_n),
      .flush    (fifoFlush),
      .push     (fifoPush),
      .pushData (fifoIn),
      .pop      (fifoPop),
      .headData (fifoHead),
      .count    (fifoCount),
      .full     (fifoFull),
      .empty    (fifoEmpty)
   );

   // ********************************************
   // derived controls
   // ********************************************
   always_comb begin
      dirIn = st_r.ctrl[CTRL_DIR_BIT]
              && !(st_r.mode == MODE_SPP || st_r.mode == MODE_PFIFO);
      fifoMode = (st_r.mode == MODE_PFIFO) || (st_r.mode == MODE_ECP)
                 || (st_r.mode == MODE_TEST);
      fwdXfer = ((st_r.mode == MODE_PFIFO) || (st_r.mode == MODE_ECP && !dirIn));
      revXfer = (st_r.mode == MODE_ECP) && dirIn;
      freeSpace = 5'h10 - fifoCount;
      statusVal = {!pinsIn.busy, pinsIn.ackN, pinsIn.paperError, pinsIn.select,
                   pinsIn.faultN, STATUS_LOW_ONES};
      ctrlRead  = {CTRL_HIGH_ONES, st_r.ctrl[5:0]};
      cfgbRead  = {1'b0, irqLineLevel, st_r.irqSelect, CFGB_LOW_ONES};
      extRead   = {st_r.mode, st_r.faultBlock, st_r.xferReqEnable, st_r.serviceFlag,
                   fifoFull, fifoEmpty};
   end

   // host and dma access to the fifo window; dma direction follows the port direction
   always_comb begin
      hostFifoWr = 1'b0;
      hostFifoRd = 1'b0;
      fifoIn     = '{tag: 1'b0, data: hostReq.wdata};
      if (hostReq.wr && hostReq.addr == OFS_FIFO && fifoMode && !dirIn)
         hostFifoWr = 1'b1;
      if (hostReq.wr && hostReq.addr == OFS_DATA && st_r.mode == MODE_ECP && !dirIn) begin
         hostFifoWr = 1'b1;
         fifoIn.tag = 1'b1;
      end
      if (st_r.mode == MODE_TEST && hostReq.wr && hostReq.addr == OFS_FIFO)
         hostFifoWr = 1'b1;
      if (dmaAck && fifoMode && !dirIn)
         hostFifoWr = 1'b1;
      if (hostReq.rd && hostReq.addr == OFS_FIFO && (revXfer || st_r.mode == MODE_TEST))
         hostFifoRd = 1'b1;
      if (dmaAck && (revXfer || (st_r.mode == MODE_TEST && dirIn)))
         hostFifoRd = 1'b1;
      if (revXfer) fifoIn.data = pdIn;
      if (revXfer) fifoIn.tag = !pinsIn.busy;
   end

   // ********************************************
   // link handshake and fifo pointers
   // ********************************************
   always_comb begin
      linkPop  = fwdXfer && st_r.link == LK_WAIT && !pinsIn.busy;
      linkPush = revXfer && st_r.link == LK_STROBE && !pinsIn.ackN;
      fifoFlush = (st_r.mode == MODE_SPP) || (st_r.mode == MODE_PS2);
      fifoPush = ((hostFifoWr && !revXfer) || linkPush) && !fifoFull;
      fifoPop  = (hostFifoRd || linkPop) && !fifoEmpty;
   end

   always_comb begin
      svcEvent = 1'b0;
      if (fifoMode && !st_r.serviceFlag) begin
         if (st_r.xferReqEnable) svcEvent = dmaTc;
         else if (!dirIn) svcEvent = (freeSpace >= {1'b0, st_r.freeThr});
         else svcEvent = (fifoCount >= {1'b0, st_r.fillThr});
      end
   end

   // ********************************************
   // next state
   // ********************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.ackPrev   = pinsIn.ackN;
      st_nxt.faultPrev = pinsIn.faultN;
      st_nxt.irq       = 1'b0;
      // acknowledge interrupt on rising edge
      if (st_r.ctrl[CTRL_ACKIE_BIT] && pinsIn.ackN && !st_r.ackPrev)
         st_nxt.irq = 1'b1;
      // fault edge, also when the block bit is released while fault is low
      if (st_r.mode == MODE_ECP && !st_r.faultBlock && !pinsIn.faultN && st_r.faultPrev)
         st_nxt.irq = 1'b1;
      if (st_r.mode == MODE_ECP && st_r.faultBlock && !pinsIn.faultN
          && hostReq.wr && hostReq.addr == OFS_EXTCTL && !hostReq.wdata[EXT_FAULTB_BIT])
         st_nxt.irq = 1'b1;
      if (svcEvent && !st_r.xferReqEnable)
         st_nxt.irq = 1'b1;

      // forward link: setup, strobe low, wait for busy release
      unique case (st_r.link)
         LK_IDLE: begin
            if (fwdXfer && !fifoEmpty && !pinsIn.busy) st_nxt.link = LK_SETUP;
            else if (revXfer && !fifoFull) st_nxt.link = LK_STROBE;
         end
         LK_SETUP: begin
            st_nxt.link = LK_STROBE;
            st_nxt.linkTag = fifoHead.tag;
         end
         LK_STROBE: begin
            if (fwdXfer && pinsIn.busy) st_nxt.link = LK_WAIT;
            else if (linkPush) st_nxt.link = LK_WAIT;
            else if (!fwdXfer && !revXfer) st_nxt.link = LK_IDLE;
         end
         LK_WAIT: begin
            if (revXfer ? pinsIn.ackN : !pinsIn.busy) st_nxt.link = LK_IDLE;
            else if (!fwdXfer && !revXfer) st_nxt.link = LK_IDLE;
         end
      endcase

      // register writes
      if (hostReq.wr) begin
         unique case (hostReq.addr)
            OFS_DATA:   if (st_r.mode == MODE_SPP || st_r.mode == MODE_PS2)
                           st_nxt.dataLatch = hostReq.wdata;
            OFS_CTRL:   st_nxt.ctrl = {2'h0, hostReq.wdata[5:0]};
            OFS_CFGB:   if (st_r.mode == MODE_CFG)
                           st_nxt.irqSelect = hostReq.wdata[5:3];
            OFS_EXTCTL: begin
               st_nxt.mode          = ecpp_mode_t'(hostReq.wdata[7:5]);
               st_nxt.faultBlock    = hostReq.wdata[EXT_FAULTB_BIT];
               st_nxt.xferReqEnable = hostReq.wdata[EXT_TRANSFER_REQUEST_ENABLE_BIT];
               st_nxt.serviceFlag   = hostReq.wdata[EXT_SVC_BIT];
            end
            OFS_THRESH: begin
               st_nxt.freeThr = hostReq.wdata[7:4];
               st_nxt.fillThr = hostReq.wdata[3:0];
            end
            default: ;
         endcase
      end
      if (svcEvent) st_nxt.serviceFlag = 1'b1;

      if (fifoPop) st_nxt.lastPop = fifoHead.data;

      // register reads, answered next cycle
      st_nxt.rdata = 8'h00;
      if (hostReq.rd) begin
         unique case (hostReq.addr)
            OFS_DATA:   st_nxt.rdata = (st_r.mode == MODE_PS2) ? pdIn
                                       : st_r.dataLatch;
            OFS_STATUS: st_nxt.rdata = statusVal;
            OFS_CTRL:   st_nxt.rdata = ctrlRead;
            OFS_FIFO:   st_nxt.rdata = (st_r.mode == MODE_CFG) ? CFGA_VALUE
                                       : (fifoEmpty ? 8'h00 : fifoHead.data);
            OFS_CFGB:   st_nxt.rdata = (st_r.mode == MODE_CFG) ? cfgbRead : 8'h00;
            OFS_EXTCTL: st_nxt.rdata = extRead;
            OFS_THRESH: st_nxt.rdata = {st_r.freeThr, st_r.fillThr};
            default:    st_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{dataLatch: 8'h00, ctrl: CTRL_RESET, mode: MODE_SPP, faultBlock: 1'b0,
                  xferReqEnable: 1'b0, serviceFlag: 1'b0, irqSelect: CFGB_IRQ_RESET,
                  freeThr: FREE_THR_RESET, fillThr: FILL_THR_RESET, rdata: 8'h00,
                  lastPop: 8'h00, link: LK_IDLE, linkTag: 1'b0, ackPrev: 1'b1,
                  faultPrev: 1'b1, irq: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ********************************************
   // outputs
   // ********************************************
   always_comb begin
      hostRdata = st_r.rdata;
      irqOut    = st_r.irq;
      dmaReq    = st_r.xferReqEnable && !st_r.serviceFlag && fifoMode
                  && (dirIn ? !fifoEmpty : !fifoFull);
      pdOe      = !dirIn;
      pdOut     = st_r.dataLatch;
      if (fwdXfer) pdOut = fifoHead.data;
      else if (st_r.mode == MODE_TEST) pdOut = st_r.lastPop;
      pinsOut.selectInN = !st_r.ctrl[CTRL_SELIN_BIT];
      pinsOut.initN     = st_r.ctrl[CTRL_INIT_BIT];
      pinsOut.autoFeedN = !st_r.ctrl[CTRL_AFD_BIT];
      pinsOut.strobeN   = !st_r.ctrl[CTRL_STB_BIT];
      if (fwdXfer) begin
         pinsOut.strobeN = !(st_r.link == LK_STROBE);
         if (st_r.mode == MODE_ECP) pinsOut.autoFeedN = !st_r.linkTag;
      end
      if (revXfer) pinsOut.autoFeedN = !(st_r.link == LK_STROBE);
   end
endmodule
`default_nettype wire

// file: verification/ecpp_monitor.sv
// checker of register reads, pin levels and interrupts of the port
// assumes binding to ecpp_port; mirrors register writes to know mode and control
`default_nettype none
module ecpp_monitor (
   input wire logic                     clk,
   input wire logic                     reset_n,
   input wire ecpp_pkg::ecpp_req_t      hostReq,
   input wire logic [7:0]               hostRdata,
   input wire ecpp_pkg::ecpp_pins_in_t  pinsIn,
   input wire ecpp_pkg::ecpp_pins_out_t pinsOut,
   input wire logic                     pdOe,
   input wire logic                     dmaReq,
   input wire logic                     irqOut,
   input wire logic                     irqLineLevel
);
   timeunit 1ns;
   timeprecision 1ps;
   import ecpp_pkg::*;
   // ******
   // shadow of written fields
   // ******
   logic [2:0] modeR;
   logic [7:0] ctrlR;
   logic [2:0] extR;
   logic [2:0] irqSelR;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         modeR   <= 3'h0;
         ctrlR   <= CTRL_RESET;
         extR    <= 3'h0;
         irqSelR <= CFGB_IRQ_RESET;
      end else if (hostReq.wr) begin
         if (hostReq.addr == OFS_CTRL) ctrlR <= hostReq.wdata;
         if (hostReq.addr == OFS_EXTCTL) modeR <= hostReq.wdata[7:5];
         if (hostReq.addr == OFS_EXTCTL) extR <= {1'b1, hostReq.wdata[4:3]};
         if (hostReq.addr == OFS_CFGB && modeR == 3'h7) irqSelR <= hostReq.wdata[5:3];
      end
   end
   // ******
   // assertions
   // ******
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence rdAt(logic [10:0] a);
      hostReq.rd && hostReq.addr == a;
   endsequence
   sequence ackRise;
      ctrlR[4] && $rose(pinsIn.ackN);
   endsequence
   AST_STATUS_READ: assert property (
      rdAt(OFS_STATUS) |=> hostRdata == {~$past(pinsIn.busy), $past(pinsIn[3:0]), 3'h7})
      else $error("status read wrong");
   AST_CTRL_READ: assert property (
      rdAt(OFS_CTRL) |=> hostRdata == {2'h3, $past(ctrlR[5:0])})
      else $error("control read wrong");
   AST_CTRL_PINS: assert property (
      (modeR inside {3'h0, 3'h1, 3'h6}) [*2]
      |-> pinsOut == {~ctrlR[0], ~ctrlR[1], ctrlR[2], ~ctrlR[3]})
      else $error("control pins wrong");
   AST_DIR_FORCED: assert property (
      (modeR inside {3'h0, 3'h2}) [*2] |-> pdOe)
      else $error("data lines not driven");
   AST_DIR_INPUT: assert property (
      (modeR == 3'h1 && ctrlR[5]) [*2] |-> !pdOe)
      else $error("data lines driven in input");
   AST_MODE_READ: assert property (
      rdAt(OFS_EXTCTL) |=> hostRdata[7:5] == $past(modeR))
      else $error("mode read wrong");
   AST_CFGA_READ: assert property (
      rdAt(OFS_FIFO) ##0 modeR == 3'h7 |=> hostRdata == 8'h10)
      else $error("config A read wrong");
   AST_CFGB_READ: assert property (
      rdAt(OFS_CFGB) ##0 modeR == 3'h7
      |=> hostRdata == {1'b0, $past(irqLineLevel), $past(irqSelR), 3'h7})
      else $error("config B read wrong");
   AST_ACK_IRQ: assert property (
      ackRise |-> ##[1:3] irqOut)
      else $error("no acknowledge interrupt");
   AST_FAULT_IRQ: assert property (
      modeR == 3'h3 && extR[2] && !extR[1] && $fell(pinsIn.faultN) |-> ##[1:3] irqOut)
      else $error("no fault interrupt");
   AST_DMA_OFF: assert property (
      extR[2] && !extR[0] |-> !dmaReq)
      else $error("transfer request while disabled");
endmodule
bind ecpp_port ecpp_monitor u_monitor (
   .clk, .reset_n, .hostReq, .hostRdata, .pinsIn, .pinsOut, .pdOe, .dmaReq, .irqOut,
   .irqLineLevel
);
`default_nettype wire

// file: verification/ecpp_periph_model.sv
// peripheral at the cable end: takes forward bytes, offers reverse bytes
// assumes the port's pins and the same clock; slow sets answer delay
`default_nettype none
module ecpp_periph_model (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire ecpp_pkg::ecpp_pins_out_t pinsOut,
   input  wire logic [7:0]               pdOut,
   input  wire logic                     pdOe,
   output var logic                      busy,
   output var logic                      ackN,
   output logic [7:0]                    pdIn
);
   timeunit 1ns;
   timeprecision 1ps;
   import ecpp_pkg::*;
   // ******
   // handshake
   // ******
   logic [8:0] capQ[$];
   int         slow    = 0;
   int         revLeft = 0;
   logic [7:0] revByte = 8'h5a;
   logic [7:0] drv     = 8'h3c;
   initial busy = 1'b0;
   initial ackN = 1'b1;
   // the wire carries the port while it drives, our level otherwise
   assign pdIn = pdOe ? pdOut : drv;
   always begin
      @(posedge clk);
      if (reset_n && pdOe && !pinsOut.strobeN && !busy) begin
         capQ.push_back({pinsOut.autoFeedN, pdOut});
         repeat (slow) @(posedge clk);
         busy <= 1'b1;
         while (!pinsOut.strobeN) @(posedge clk);
         repeat (slow) @(posedge clk);
         busy <= 1'b0;
      end else if (revLeft > 0 && !pdOe && !pinsOut.autoFeedN) begin
         drv <= revByte;
         busy <= 1'b1;
         repeat (slow + 1) @(posedge clk);
         ackN <= 1'b0;
         repeat (2) @(posedge clk);
         ackN <= 1'b1;
         busy <= 1'b0;
         drv <= ~revByte;
         revByte <= revByte + 8'h01;
         revLeft <= revLeft - 1;
         repeat (2) @(posedge clk);
      end
   end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench of the parallel port register block
// assumes ecpp_port, its checker and the peripheral model compiled first
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ecpp_pkg::*;
   // ******
   // harness
   // ******
   logic           clk     = 1'b0;
   logic           reset_n = 1'b0;
   ecpp_req_t      hostReq = '0;
   ecpp_pins_in_t  pinsIn;
   ecpp_pins_out_t pinsOut;
   logic [7:0]     hostRdata, pdIn, pdOut, d;
   logic           pdOe, dmaReq, irqOut, mBusy, mAckN;
   logic           pe = 1'b0, sel = 1'b0, faultN = 1'b1, irqLvl = 1'b0, tc = 1'b0;
   int             n_fail = 0, n_compared = 0, irqCnt = 0, cyc = 0, k, base;
   always #2 clk = ~clk;
   assign pinsIn = {mBusy, mAckN, pe, sel, faultN};
   ecpp_port u_dut (.clk, .reset_n, .hostReq, .hostRdata, .pinsIn, .pinsOut, .pdIn,
      .pdOut, .pdOe, .dmaAck(1'b0), .dmaTc(tc), .dmaReq, .irqOut, .irqLineLevel(irqLvl));
   ecpp_periph_model u_model (.clk, .reset_n, .pinsOut, .pdOut, .pdOe, .busy(mBusy),
      .ackN(mAckN), .pdIn);
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (irqOut === 1'b1) irqCnt <= irqCnt + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] v);
      hostReq.addr <= a;
      hostReq.wdata <= v;
      hostReq.wr <= 1'b1;
      @(posedge clk);
      hostReq.wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [10:0] a);
      hostReq.addr <= a;
      hostReq.rd <= 1'b1;
      @(posedge clk);
      hostReq.rd <= 1'b0;
      #1 d = hostRdata;
      @(posedge clk);
   endtask
   task automatic rc(input logic [10:0] a, input logic [7:0] e);
      rd(a);
      chk({1'b0, d}, {1'b0, e});
   endtask
   // waits for the peripheral to hold n bytes, then lets the link settle
   task automatic waitFor(input int n);
      for (int i = 0; i < 500 && u_model.capQ.size() < n; i++) @(posedge clk);
      repeat (8) @(posedge clk);
   endtask
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ******
   // sequence
   // ******
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      chk({5'h0, pinsOut}, 9'h00d);
      rc(OFS_CTRL, 8'hc0);
      rd(OFS_EXTCTL);
      chk({1'b0, d & 8'he3}, 9'h001);
      pe <= 1'b1;
      @(posedge clk);
      rc(OFS_STATUS, 8'hef);
      pe <= 1'b0;
      sel <= 1'b1;
      faultN <= 1'b0;
      @(posedge clk);
      rc(OFS_STATUS, 8'hd7);
      faultN <= 1'b1;
      wr(OFS_CTRL, 8'h2f);
      chk({5'h0, pinsOut}, 9'h002);
      rc(OFS_CTRL, 8'hef);
      chk({8'h0, pdOe}, 9'h001);
      wr(OFS_CTRL, 8'h20);
      u_model.capQ.delete();
      wr(OFS_EXTCTL, 8'h30);
      chk({8'h0, pdOe}, 9'h000);
      rc(OFS_DATA, 8'h3c);
      wr(OFS_EXTCTL, 8'hf0);
      rc(OFS_FIFO, 8'h10);
      wr(OFS_CFGB, 8'h28);
      irqLvl <= 1'b1;
      @(posedge clk);
      rc(OFS_CFGB, 8'h6f);
      rd(OFS_EXTCTL);
      chk({6'h0, d[7:5]}, 9'h007);
      wr(OFS_EXTCTL, 8'h14);
      wr(OFS_CTRL, 8'h00);
      wr(OFS_EXTCTL, 8'hd4);
      for (k = 0; k < 16; k++) wr(OFS_FIFO, 8'h11 * k[7:0]);
      rd(OFS_EXTCTL);
      chk({7'h0, d[1:0]}, 9'h002);
      wr(OFS_FIFO, 8'hee);
      for (k = 0; k < 16; k++) rc(OFS_FIFO, 8'h11 * k[7:0]);
      rd(OFS_EXTCTL);
      chk({7'h0, d[1:0]}, 9'h001);
      rc(OFS_FIFO, 8'h00);
      chk(9'(u_model.capQ.size()), 9'h000);
      base = irqCnt;
      wr(OFS_EXTCTL, 8'hd0);
      repeat (4) @(posedge clk);
      rd(OFS_EXTCTL);
      chk({8'h0, d[2]}, 9'h001);
      wr(OFS_EXTCTL, 8'hd4);
      chk(9'(irqCnt - base), 9'h001);
      for (k = 0; k < 9; k++) wr(OFS_FIFO, 8'h01);
      wr(OFS_EXTCTL, 8'hd0);
      rd(OFS_EXTCTL);
      chk({8'h0, d[2]}, 9'h000);
      wr(OFS_EXTCTL, 8'h14);
      rd(OFS_EXTCTL);
      chk({7'h0, d[1:0]}, 9'h001);
      u_model.slow = 4;
      wr(OFS_EXTCTL, 8'h74);
      wr(OFS_DATA, 8'ha5);
      wr(OFS_FIFO, 8'h3c);
      wr(OFS_DATA, 8'h81);
      waitFor(3);
      chk(u_model.capQ[0], 9'h0a5);
      chk(u_model.capQ[1], 9'h13c);
      chk(u_model.capQ[2], 9'h081);
      base = irqCnt;
      faultN <= 1'b0;
      repeat (3) @(posedge clk);
      wr(OFS_EXTCTL, 8'h64);
      faultN <= 1'b1;
      @(posedge clk);
      faultN <= 1'b0;
      repeat (4) @(posedge clk);
      chk(9'(irqCnt - base), 9'h002);
      faultN <= 1'b1;
      wr(OFS_EXTCTL, 8'h14);
      wr(OFS_EXTCTL, 8'h54);
      u_model.slow = 0;
      wr(OFS_FIFO, 8'h77);
      waitFor(4);
      chk(u_model.capQ[3], 9'h177);
      wr(OFS_EXTCTL, 8'h34);
      wr(OFS_CTRL, 8'h30);
      wr(OFS_EXTCTL, 8'h74);
      base = irqCnt;
      u_model.revLeft = 3;
      for (int i = 0; i < 500 && u_model.revLeft > 0; i++) @(posedge clk);
      repeat (4) @(posedge clk);
      for (k = 0; k < 3; k++) rc(OFS_FIFO, 8'h5a + k[7:0]);
      chk(9'(irqCnt - base), 9'h003);
      wr(OFS_EXTCTL, 8'h14);
      wr(OFS_CTRL, 8'h00);
      wr(OFS_EXTCTL, 8'h58);
      chk({8'h0, dmaReq}, 9'h001);
      tc <= 1'b1;
      @(posedge clk);
      tc <= 1'b0;
      @(posedge clk);
      chk({8'h0, dmaReq}, 9'h000);
      rd(OFS_EXTCTL);
      chk({8'h0, d[2]}, 9'h001);
      wr(OFS_EXTCTL, 8'h50);
      chk({8'h0, dmaReq}, 9'h000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
